/* logic/rpe_power_engine.sv */
`timescale 1ns/1ps
`include "rpe_map.svh"
// Notes on behaviour
// - take 16-bit current/voltage samples at 900 kHz
// - high-pass removes dc from current when on
// - filter enable pin high turns high-pass on
// - instantaneous power is current times voltage
// - low-pass power product to get real power
// - low-pass is first order, corner near 8.9 Hz
// - low-rate pulses from long real power accumulation
// - two alternating outputs drive counter or stepper
// - calibration pulses faster, shorter integration
// - rate-select pin scales calibration pulse frequency
// - reverse flag high on negative real power
// - reverse flag not latched, clears on positive
// - reverse flag changes only with calibration pulse
// - rates derived from 3.5795 MHz nominal master clock; the code derives them from the 125 MHz I_CLK
// - reset low clears accumulators and counters; run bit resets high, threshold to 0x0001_0000
module rpe_power_engine import rpe_pkg::*; #(
  parameter int unsigned LR_PULSE_CYC = `RPE_LR_PULSE_CYC,
  parameter int unsigned CP_PULSE_CYC = `RPE_CP_PULSE_CYC
) (
  input wire logic I_CLK, // 125 MHz master clock
  input wire logic I_RESET_N, // async reset, active low
  input wire logic [15:0] I_CUR_SAMPLE, // current sample, signed
  input wire logic [15:0] I_VOLT_SAMPLE, // voltage sample, signed
  input wire logic I_SAMPLE_VALID, // sample pair offered
  output logic O_SAMPLE_READY, // sample pair accepted
  input wire logic I_CURRENT_HPF_ENABLE, // high-pass on when high
  input wire logic I_CALIBRATION_RATE_SELECT, // calibration scaling
  output logic O_LOW_RATE_PULSE_A, // low-rate phase a
  output logic O_LOW_RATE_PULSE_B, // low-rate phase b
  output logic O_CALIBRATION_PULSE_OUT, // calibration pulse
  output logic O_REVERSE_POWER_FLAG, // negative power seen
  input wire logic I_WB_CYC, // wishbone cycle
  input wire logic I_WB_STB, // wishbone strobe
  input wire logic I_WB_WE, // wishbone write
  input wire logic [7:0] I_WB_ADR, // wishbone byte address
  input wire logic [3:0] I_WB_SEL, // wishbone byte lanes
  input wire logic [31:0] I_WB_DAT, // wishbone write data
  output logic [31:0] O_WB_DAT, // wishbone read data
  output logic O_WB_ACK // wishbone acknowledge
);
  // =====================================================
  // declarations
  localparam logic [7:0] DIV_LAST = 8'(`RPE_SAMPLE_DIV - 1);
  localparam logic [31:0] LR_CYC = 32'(LR_PULSE_CYC);
  localparam logic [31:0] CP_CYC = 32'(CP_PULSE_CYC);

  logic [7:0] div_q;
  logic tick_w;
  logic fifo_valid_w, fifo_ready_w, fire_w;
  logic [`RPE_FIFO_W-1:0] fifo_data_w;
  logic signed [15:0] cur_q, volt_q;
  logic v0_q, v1_q, v2_q;
  logic signed [15:0] dc_w;
  logic signed [`RPE_HP_W-1:0] hp_w;
  logic signed [`RPE_PROD_W-1:0] prod_w, prod_q, lp_w;
  logic signed [`RPE_ACC_W-1:0] add_w, lr_th_w, cp_th_w;
  logic signed [`RPE_ACC_W-1:0] cp_acc_q, cp_sum_w, cp_acc_d;
  logic signed [`RPE_ACC_W-1:0] lr_acc_q, lr_sum_w, lr_acc_d;
  logic cp_pos_w, cp_neg_w, cp_evt_w, lr_evt_w;
  logic cp_pend_q, cp_pend_neg_q, cp_start_w;
  logic [31:0] cp_cnt_q, cp_cnt_d;
  logic cp_out_q, rev_q;
  rpe_lr_state_t lr_state_q, lr_state_d;
  logic [31:0] lr_cnt_q, lr_cnt_d;
  logic [3:0] lr_pend_q;
  logic lr_idle_w, lr_take_w, lr_a_q, lr_b_q;
  logic run_q;
  logic [31:0] lr_thresh_q, cal_count_q, lr_count_q;
  logic wb_req_w, wb_wr_w, ack_q;
  logic sel_ctrl_w, sel_stat_w, sel_thr_w, sel_calc_w, sel_lrc_w, sel_pow_w;
  logic clr_cnt_w;
  logic [31:0] status_w, rd_mux_w, rd_q;

  // =====================================================
  // oversample enable: 125 MHz / 900 kHz, one pulse per sample slot
  // the 3.5795 MHz nominal master clock gives the same 900 kHz
  // as master / 4, so all filter constants keep their meaning
  assign tick_w = (div_q == DIV_LAST);

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      div_q <= 8'h00;
    end else begin
      div_q <= tick_w ? 8'h00 : div_q + 8'h01;
    end
  end

  // =====================================================
  // sample fifo: the source stalls on O_SAMPLE_READY when the
  // oversample slots drain slower than samples arrive
  rpe_fifo #(
    .W(`RPE_FIFO_W),
    .D(`RPE_FIFO_D)
  ) u_fifo (
    .i_clk(I_CLK),
    .i_reset_n(I_RESET_N),
    .i_wr_valid(I_SAMPLE_VALID),
    .o_wr_ready(O_SAMPLE_READY),
    .i_wr_data({I_CUR_SAMPLE, I_VOLT_SAMPLE}),
    .o_rd_valid(fifo_valid_w),
    .i_rd_ready(fifo_ready_w),
    .o_rd_data(fifo_data_w)
  );

  // one pair per slot, and only while running
  assign fifo_ready_w = tick_w & run_q;
  assign fire_w = fifo_valid_w & fifo_ready_w;

  // stage 0: capture the 16-bit pair
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      cur_q <= 16'sh0000;
      volt_q <= 16'sh0000;
      v0_q <= 1'b0;
      v1_q <= 1'b0;
      v2_q <= 1'b0;
      prod_q <= '0;
    end else begin
      if (fire_w) begin
        cur_q <= fifo_data_w[31:16];
        volt_q <= fifo_data_w[15:0];
      end
      v0_q <= fire_w;
      v1_q <= v0_q;
      v2_q <= v1_q;
      if (v0_q) begin
        prod_q <= prod_w;
      end
    end
  end

  // =====================================================
  // current high-pass: track dc with a slow low-pass and subtract
  // estimator freezes while bypassed so re-enable settles quickly
  rpe_iir1 #(
    .W(`RPE_SAMPLE_W),
    .K(`RPE_HPF_SHIFT)
  ) u_dc_track (
    .i_clk(I_CLK),
    .i_reset_n(I_RESET_N),
    .i_en(v0_q & I_CURRENT_HPF_ENABLE),
    .i_x(cur_q),
    .o_y(dc_w)
  );

  // pin high selects the filtered current
  assign hp_w = I_CURRENT_HPF_ENABLE ? (17'(cur_q) - 17'(dc_w)) : 17'(cur_q);

  // direct product, full 33-bit precision
  assign prod_w = 33'(hp_w) * 33'(volt_q);

  // =====================================================
  // real-power low-pass: first order, alpha 2^-14 at 900 kHz
  // gives a corner of about 8.7 Hz, nearest power of two to 8.9 Hz
  rpe_iir1 #(
    .W(`RPE_PROD_W),
    .K(`RPE_LPF_SHIFT)
  ) u_power_lpf (
    .i_clk(I_CLK),
    .i_reset_n(I_RESET_N),
    .i_en(v1_q),
    .i_x(prod_q),
    .o_y(lp_w)
  );

  // =====================================================
  // digital-to-frequency: signed accumulators against thresholds
  // calibration threshold is the low-rate one shifted down
  assign add_w = `RPE_ACC_W'(lp_w);
  assign lr_th_w = `RPE_ACC_W'({lr_thresh_q, 16'h0000});
  assign cp_th_w = I_CALIBRATION_RATE_SELECT ? (lr_th_w >>> `RPE_CP_SHIFT_HI)
                                             : (lr_th_w >>> `RPE_CP_SHIFT_LO);

  // calibration accumulator, short integration
  assign cp_sum_w = cp_acc_q + add_w;
  assign cp_pos_w = v2_q & (cp_sum_w >= cp_th_w);
  assign cp_neg_w = v2_q & ~cp_pos_w & (cp_sum_w <= -cp_th_w);
  assign cp_evt_w = cp_pos_w | cp_neg_w;
  assign cp_acc_d = !v2_q ? cp_acc_q :
                    cp_pos_w ? (cp_sum_w - cp_th_w) :
                    cp_neg_w ? (cp_sum_w + cp_th_w) : cp_sum_w;

  // low-rate accumulator, long integration averages out 2x line ripple
  assign lr_sum_w = lr_acc_q + add_w;
  assign lr_evt_w = v2_q & ((lr_sum_w >= lr_th_w) | (lr_sum_w <= -lr_th_w));
  assign lr_acc_d = !v2_q ? lr_acc_q :
                    (lr_sum_w >= lr_th_w) ? (lr_sum_w - lr_th_w) :
                    (lr_sum_w <= -lr_th_w) ? (lr_sum_w + lr_th_w) : lr_sum_w;

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      cp_acc_q <= '0;
      lr_acc_q <= '0;
    end else begin
      cp_acc_q <= cp_acc_d;
      lr_acc_q <= lr_acc_d;
    end
  end

  // =====================================================
  // calibration pulse: high CP_CYC, then low at least CP_CYC + 1 before the next
  // one pulse may wait; a second event while waiting merges into it
  assign cp_start_w = cp_pend_q & (cp_cnt_q == 32'h0000_0000);
  assign cp_cnt_d = cp_start_w ? {CP_CYC[30:0], 1'b0} :
                    (cp_cnt_q != 32'h0000_0000) ? cp_cnt_q - 32'h0000_0001 : cp_cnt_q;

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      cp_pend_q <= 1'b0;
      cp_pend_neg_q <= 1'b0;
      cp_cnt_q <= 32'h0000_0000;
      cp_out_q <= 1'b0;
      rev_q <= 1'b0;
    end else begin
      // a new event wins over the clear of the pending bit
      cp_pend_q <= cp_evt_w | (cp_pend_q & ~cp_start_w);
      if (cp_evt_w) begin
        cp_pend_neg_q <= cp_neg_w;
      end
      cp_cnt_q <= cp_cnt_d;
      cp_out_q <= (cp_cnt_d > CP_CYC);
      if (cp_start_w) begin
        rev_q <= cp_pend_neg_q;
      end
    end
  end

  // =====================================================
  // low-rate stepper drive: pulses alternate a, b, a, b so a
  // two-phase motor steps; each pulse lasts LR_CYC and each gap at least LR_CYC
  assign lr_idle_w = (lr_state_q == RPE_LR_IDLE_A) | (lr_state_q == RPE_LR_IDLE_B);
  assign lr_take_w = lr_idle_w & (lr_cnt_q == 32'h0000_0000) & (lr_pend_q != 4'h0);

  always_comb begin
    lr_state_d = lr_state_q;
    lr_cnt_d = (lr_cnt_q != 32'h0000_0000) ? lr_cnt_q - 32'h0000_0001 : lr_cnt_q;
    case (lr_state_q)
      RPE_LR_IDLE_A: begin
        if (lr_take_w) begin
          lr_state_d = RPE_LR_DRIVE_A;
          lr_cnt_d = LR_CYC - 32'h0000_0001;
        end
      end
      RPE_LR_DRIVE_A: begin
        if (lr_cnt_q == 32'h0000_0000) begin
          lr_state_d = RPE_LR_IDLE_B;
          lr_cnt_d = LR_CYC - 32'h0000_0001;
        end
      end
      RPE_LR_IDLE_B: begin
        if (lr_take_w) begin
          lr_state_d = RPE_LR_DRIVE_B;
          lr_cnt_d = LR_CYC - 32'h0000_0001;
        end
      end
      RPE_LR_DRIVE_B: begin
        if (lr_cnt_q == 32'h0000_0000) begin
          lr_state_d = RPE_LR_IDLE_A;
          lr_cnt_d = LR_CYC - 32'h0000_0001;
        end
      end
      default: begin
        lr_state_d = RPE_LR_IDLE_A;
        lr_cnt_d = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      lr_state_q <= RPE_LR_IDLE_A;
      lr_cnt_q <= 32'h0000_0000;
      lr_pend_q <= 4'h0;
      lr_a_q <= 1'b0;
      lr_b_q <= 1'b0;
    end else begin
      lr_state_q <= lr_state_d;
      lr_cnt_q <= lr_cnt_d;
      // backlog saturates; a meter rarely outruns a 275 ms pulse
      if (lr_evt_w && !lr_take_w && lr_pend_q != `RPE_PEND_MAX) begin
        lr_pend_q <= lr_pend_q + 4'h1;
      end else if (!lr_evt_w && lr_take_w) begin
        lr_pend_q <= lr_pend_q - 4'h1;
      end
      lr_a_q <= (lr_state_d == RPE_LR_DRIVE_A);
      lr_b_q <= (lr_state_d == RPE_LR_DRIVE_B);
    end
  end

  assign O_LOW_RATE_PULSE_A = lr_a_q;
  assign O_LOW_RATE_PULSE_B = lr_b_q;
  assign O_CALIBRATION_PULSE_OUT = cp_out_q;
  assign O_REVERSE_POWER_FLAG = rev_q;

  // =====================================================
  // wishbone slave: ack one cycle after the request, dropped next
  assign wb_req_w = I_WB_CYC & I_WB_STB;
  assign wb_wr_w = wb_req_w & I_WB_WE & ack_q;
  assign sel_ctrl_w = (I_WB_ADR == `RPE_ADR_CTRL);
  assign sel_stat_w = (I_WB_ADR == `RPE_ADR_STATUS);
  assign sel_thr_w = (I_WB_ADR == `RPE_ADR_LR_THRESH);
  assign sel_calc_w = (I_WB_ADR == `RPE_ADR_CAL_COUNT);
  assign sel_lrc_w = (I_WB_ADR == `RPE_ADR_LR_COUNT);
  assign sel_pow_w = (I_WB_ADR == `RPE_ADR_POWER);
  assign clr_cnt_w = wb_wr_w & sel_ctrl_w & I_WB_SEL[0] & I_WB_DAT[`RPE_CTRL_CLR_BIT];

  // status shows live block state
  assign status_w = {20'h0_0000, lr_pend_q, 2'b00, lr_state_q, cp_pend_q, cp_out_q,
                     I_CURRENT_HPF_ENABLE, rev_q};

  // unmapped addresses read zero and still ack
  assign rd_mux_w = sel_ctrl_w ? {31'h0000_0000, run_q} :
                    sel_stat_w ? status_w :
                    sel_thr_w ? lr_thresh_q :
                    sel_calc_w ? cal_count_q :
                    sel_lrc_w ? lr_count_q :
                    sel_pow_w ? lp_w[32:1] : 32'h0000_0000;

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ack_q <= 1'b0;
      rd_q <= 32'h0000_0000;
      run_q <= `RPE_CTRL_RST;
    end else begin
      ack_q <= wb_req_w & ~ack_q;
      if (wb_req_w && !ack_q) begin
        rd_q <= rd_mux_w;
      end
      if (wb_wr_w && sel_ctrl_w && I_WB_SEL[0]) begin
        run_q <= I_WB_DAT[`RPE_CTRL_RUN_BIT];
      end
    end
  end

  // threshold written per byte lane
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_thr_lane
      always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
          lr_thresh_q[b*8 +: 8] <= 8'(`RPE_LR_THRESH_RST >> (b * 8));
        end else if (wb_wr_w && sel_thr_w && I_WB_SEL[b]) begin
          lr_thresh_q[b*8 +: 8] <= I_WB_DAT[b*8 +: 8];
        end
      end
    end
  endgenerate

  // pulse counters; a count arriving with a clear is kept
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      cal_count_q <= 32'h0000_0000;
      lr_count_q <= 32'h0000_0000;
    end else begin
      cal_count_q <= clr_cnt_w ? 32'(cp_start_w) : cal_count_q + 32'(cp_start_w);
      lr_count_q <= clr_cnt_w ? 32'(lr_take_w) : lr_count_q + 32'(lr_take_w);
    end
  end

  assign O_WB_ACK = ack_q;
  assign O_WB_DAT = rd_q;
endmodule

/* logic/rpe_map.svh */
`ifndef RPE_MAP_SVH
`define RPE_MAP_SVH
// ==========================================================
// clock and sample timing
`define RPE_CLK_HZ 125000000
`define RPE_OSR_HZ 900000
`define RPE_SAMPLE_DIV (`RPE_CLK_HZ / `RPE_OSR_HZ)
`define RPE_MCLK_HZ 3579500
`define RPE_MCLK_PER_SAMPLE 4
`define RPE_LR_PULSE_MS 275
`define RPE_LR_PULSE_CYC (`RPE_LR_PULSE_MS * (`RPE_CLK_HZ / 1000))
`define RPE_CP_PULSE_US 90
`define RPE_CP_PULSE_CYC (`RPE_CP_PULSE_US * (`RPE_CLK_HZ / 1000000))
// ==========================================================
// datapath widths and filter shifts
`define RPE_SAMPLE_W 16
`define RPE_HP_W 17
`define RPE_PROD_W 33
`define RPE_ACC_W 56
`define RPE_HPF_SHIFT 12
`define RPE_LPF_CORNER_DHZ 89
`define RPE_LPF_SHIFT 14
`define RPE_CP_SHIFT_LO 6
`define RPE_CP_SHIFT_HI 7
`define RPE_FIFO_W 32
`define RPE_FIFO_D 4
`define RPE_PEND_MAX 4'hF
// ==========================================================
// register map (byte addresses)
`define RPE_ADR_CTRL 8'h00
`define RPE_ADR_STATUS 8'h04
`define RPE_ADR_LR_THRESH 8'h08
`define RPE_ADR_CAL_COUNT 8'h0C
`define RPE_ADR_LR_COUNT 8'h10
`define RPE_ADR_POWER 8'h14
`define RPE_CTRL_RUN_BIT 0
`define RPE_CTRL_CLR_BIT 1
`define RPE_CTRL_RST 1'b1
`define RPE_LR_THRESH_RST 32'h0001_0000
`endif

/* logic/rpe_pkg.sv */
package rpe_pkg;
  // low-rate stepper phases, gray along the loop
  typedef enum logic [1:0] {
    RPE_LR_IDLE_A = 2'b00,
    RPE_LR_DRIVE_A = 2'b01,
    RPE_LR_IDLE_B = 2'b11,
    RPE_LR_DRIVE_B = 2'b10
  } rpe_lr_state_t;
endpackage

/* logic/rpe_fifo.sv */
`timescale 1ns/1ps
module rpe_fifo #(
  parameter int W = 32,
  parameter int D = 4
) (
  input wire logic i_clk, // master clock
  input wire logic i_reset_n, // async reset, active low
  input wire logic i_wr_valid, // source offers a word
  output logic o_wr_ready, // room for a word
  input wire logic [W-1:0] i_wr_data, // word in
  output logic o_rd_valid, // word available
  input wire logic i_rd_ready, // drain takes the word
  output logic [W-1:0] o_rd_data // head word
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wr_ptr_q, rd_ptr_q;
  logic [CW-1:0] count_q;
  logic push_w, pop_w;

  // =====================================================
  // handshakes: honest full and empty
  assign o_wr_ready = (count_q != CW'(D));
  assign o_rd_valid = (count_q != '0);
  assign push_w = i_wr_valid & o_wr_ready;
  assign pop_w = o_rd_valid & i_rd_ready;
  assign o_rd_data = mem_q[rd_ptr_q];

  // storage, no reset needed for data words
  always_ff @(posedge i_clk) begin
    if (push_w) begin
      mem_q[wr_ptr_q] <= i_wr_data;
    end
  end

  // pointers wrap at depth
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push_w) begin
        wr_ptr_q <= (wr_ptr_q == AW'(D - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop_w) begin
        rd_ptr_q <= (rd_ptr_q == AW'(D - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      count_q <= count_q + CW'(push_w) - CW'(pop_w);
    end
  end
endmodule

/* logic/rpe_iir1.sv */
`timescale 1ns/1ps
module rpe_iir1 #(
  parameter int W = 16,
  parameter int K = 12
) (
  input wire logic i_clk, // master clock
  input wire logic i_reset_n, // async reset, active low
  input wire logic i_en, // one update per sample
  input wire logic signed [W-1:0] i_x, // filter input
  output logic signed [W-1:0] o_y // low-pass state
);
  logic signed [W+K:0] acc_q, acc_d, x_w, diff_w;

  // =====================================================
  // first-order section: y += (x - y) / 2^K
  // fractional bits kept so tiny inputs still move the state
  assign x_w = {i_x[W-1], i_x, {K{1'b0}}};
  assign diff_w = x_w - acc_q;
  assign acc_d = acc_q + (diff_w >>> K);
  assign o_y = acc_q[W+K-1:K];

  // state update on sample enable only
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      acc_q <= '0;
    end else if (i_en) begin
      acc_q <= acc_d;
    end
  end
endmodule

/* test/rpe_meter_model.sv */
`timescale 1ns/1ps
// ====
// counter and two-phase stepper on the pulse pins
module rpe_meter_model (
  input wire logic i_clk, // master clock
  input wire logic i_reset_n, // design reset, resyncs the motor
  input wire logic i_phase_a, // low-rate phase a
  input wire logic i_phase_b, // low-rate phase b
  input wire logic i_cal, // calibration pulse
  output logic [15:0] o_steps, // motor steps taken
  output logic [15:0] o_cal_count, // calibration pulses seen
  output logic o_order_bad // same phase twice in a row
);
  logic a_q;
  logic b_q;
  logic cal_q;
  logic last_a_q;
  // a motor only advances when the phases alternate, so a repeat is a fault
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      cal_q <= 1'b0;
      last_a_q <= 1'b0;
      o_order_bad <= 1'b0;
      o_steps <= 16'h0000;
      o_cal_count <= 16'h0000;
    end else begin
      a_q <= i_phase_a;
      b_q <= i_phase_b;
      cal_q <= i_cal;
      if (i_phase_a && !a_q) begin
        o_steps <= o_steps + 16'h0001;
        o_order_bad <= o_order_bad | last_a_q;
        last_a_q <= 1'b1;
      end
      if (i_phase_b && !b_q) begin
        o_steps <= o_steps + 16'h0001;
        o_order_bad <= o_order_bad | !last_a_q;
        last_a_q <= 1'b0;
      end
      if (i_cal && !cal_q) begin
        o_cal_count <= o_cal_count + 16'h0001;
      end
    end
  end
endmodule

/* test/rpe_power_engine_properties.sv */
`timescale 1ns/1ps
// ====
// pulse shape, flag timing and bus answer checks
module rpe_power_chk #(
  parameter int unsigned LR_PULSE_CYC = 8,
  parameter int unsigned CP_PULSE_CYC = 4
) (
  input wire logic I_CLK, // master clock
  input wire logic I_RESET_N, // async reset, active low
  input wire logic I_WB_CYC, // wishbone cycle
  input wire logic I_WB_STB, // wishbone strobe
  input wire logic O_WB_ACK, // wishbone acknowledge
  input wire logic O_LOW_RATE_PULSE_A, // low-rate phase a
  input wire logic O_LOW_RATE_PULSE_B, // low-rate phase b
  input wire logic O_CALIBRATION_PULSE_OUT, // calibration pulse
  input wire logic O_REVERSE_POWER_FLAG // negative power seen
);
  logic [31:0] cal_hi_q;
  logic [31:0] cal_lo_q;
  logic [31:0] a_hi_q;
  logic [31:0] b_hi_q;
  logic last_a_q;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  // run lengths in counters, since pulse widths are too long to unroll
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      cal_hi_q <= '0;
      cal_lo_q <= '0;
      a_hi_q <= '0;
      b_hi_q <= '0;
      last_a_q <= 1'b0;
    end else begin
      cal_hi_q <= O_CALIBRATION_PULSE_OUT ? cal_hi_q + 32'd1 : '0;
      cal_lo_q <= O_CALIBRATION_PULSE_OUT ? '0 : cal_lo_q + 32'd1;
      a_hi_q <= O_LOW_RATE_PULSE_A ? a_hi_q + 32'd1 : '0;
      b_hi_q <= O_LOW_RATE_PULSE_B ? b_hi_q + 32'd1 : '0;
      last_a_q <= O_LOW_RATE_PULSE_A | (last_a_q & !O_LOW_RATE_PULSE_B);
    end
  end
  sequence wb_take_s;
    I_WB_CYC && I_WB_STB && !O_WB_ACK;
  endsequence
  sequence wb_answer_s;
    O_WB_ACK ##1 !O_WB_ACK;
  endsequence
  flag_at_cal_a: assert property ($changed(O_REVERSE_POWER_FLAG)
    |-> $rose(O_CALIBRATION_PULSE_OUT)) else $error("flag moved without cal pulse");
  cal_width_a: assert property ($fell(O_CALIBRATION_PULSE_OUT)
    |-> cal_hi_q == CP_PULSE_CYC) else $error("cal pulse width wrong");
  cal_gap_a: assert property ($rose(O_CALIBRATION_PULSE_OUT)
    |-> cal_lo_q >= CP_PULSE_CYC) else $error("cal pulses too close");
  lr_a_width_a: assert property ($fell(O_LOW_RATE_PULSE_A)
    |-> a_hi_q == LR_PULSE_CYC) else $error("phase a width wrong");
  lr_b_width_a: assert property ($fell(O_LOW_RATE_PULSE_B)
    |-> b_hi_q == LR_PULSE_CYC) else $error("phase b width wrong");
  lr_excl_a: assert property (!(O_LOW_RATE_PULSE_A && O_LOW_RATE_PULSE_B))
    else $error("both phases high");
  lr_alt_a: assert property (($rose(O_LOW_RATE_PULSE_A) || $rose(O_LOW_RATE_PULSE_B))
    |-> ($rose(O_LOW_RATE_PULSE_A) != last_a_q)) else $error("phases not alternating");
  wb_answer_a: assert property (wb_take_s |=> wb_answer_s)
    else $error("bus answer wrong");
  wb_cause_a: assert property ($rose(O_WB_ACK)
    |-> $past(I_WB_CYC && I_WB_STB)) else $error("ack without request");
endmodule
bind rpe_power_engine rpe_power_chk #(
  .LR_PULSE_CYC(LR_PULSE_CYC),
  .CP_PULSE_CYC(CP_PULSE_CYC)
) i_rpe_power_chk (
  .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB),
  .O_WB_ACK(O_WB_ACK), .O_LOW_RATE_PULSE_A(O_LOW_RATE_PULSE_A),
  .O_LOW_RATE_PULSE_B(O_LOW_RATE_PULSE_B), .O_CALIBRATION_PULSE_OUT(O_CALIBRATION_PULSE_OUT),
  .O_REVERSE_POWER_FLAG(O_REVERSE_POWER_FLAG)
);

/* test/testbench.sv */
`timescale 1ns/1ps
`include "rpe_map.svh"
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] cur = 16'h0000;
  logic [15:0] volt = 16'h0000;
  logic valid = 1'b0;
  logic highpass_filter = 1'b0;
  logic sel = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic ready, lr_a, lr_b, cal, flag, ack, order_bad;
  logic [31:0] rdat;
  logic [31:0] q;
  logic [15:0] steps, cal_seen;
  logic [15:0] cnt [2];
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  // ====
  // clock, design, far-side model
  always #4 clk = ~clk;
  rpe_power_engine #(.LR_PULSE_CYC(8), .CP_PULSE_CYC(4)) i_rpe_power_engine (
    .I_CLK(clk), .I_RESET_N(rst_n), .I_CUR_SAMPLE(cur), .I_VOLT_SAMPLE(volt),
    .I_SAMPLE_VALID(valid), .O_SAMPLE_READY(ready), .I_CURRENT_HPF_ENABLE(highpass_filter),
    .I_CALIBRATION_RATE_SELECT(sel), .O_LOW_RATE_PULSE_A(lr_a), .O_LOW_RATE_PULSE_B(lr_b),
    .O_CALIBRATION_PULSE_OUT(cal), .O_REVERSE_POWER_FLAG(flag), .I_WB_CYC(cyc),
    .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hF), .I_WB_DAT(wdat),
    .O_WB_DAT(rdat), .O_WB_ACK(ack));
  rpe_meter_model i_rpe_meter_model (.i_clk(clk), .i_reset_n(rst_n), .i_phase_a(lr_a),
    .i_phase_b(lr_b), .i_cal(cal), .o_steps(steps), .o_cal_count(cal_seen),
    .o_order_bad(order_bad));
  // hang guard, well above the few thousand cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      close_out();
    end
  end
  // ====
  // tasks
  task close_out;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task reset_dut;
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  // one classic cycle; read data is taken on the edge that sees ack
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    chk("bus ack", 32'h1, {31'h0, ack});
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000);
    chk(name, exp, q);
  endtask
  // the pair is held until the fifo shows room
  task push(input logic [15:0] c, input logic [15:0] v);
    int n;
    n = 0;
    @(posedge clk);
    valid <= 1'b1;
    cur <= c;
    volt <= v;
    do begin
      @(posedge clk);
      n++;
    end while (ready !== 1'b1 && n < 1000);
    chk("sample taken", 32'h1, {31'h0, ready});
    valid <= 1'b0;
  endtask
  // ====
  // scenarios
  initial begin
    reset_dut();
    chk("reset outputs", 32'h1, {27'h0, lr_a, lr_b, cal, flag, ready});
    rd("ctrl", `RPE_ADR_CTRL, 32'h0000_0001);
    rd("threshold", `RPE_ADR_LR_THRESH, `RPE_LR_THRESH_RST);
    rd("unmapped", 8'h3C, 32'h0000_0000);
    wb(1'b1, `RPE_ADR_CTRL, 32'h0000_0000);
    push(16'h4000, 16'h4000);
    wb(1'b1, `RPE_ADR_CTRL, 32'h0000_0001);
    repeat (160) @(posedge clk);
    rd("power one", `RPE_ADR_POWER, 32'h0000_2000);
    push(16'h4000, 16'h4000);
    repeat (160) @(posedge clk);
    rd("power two", `RPE_ADR_POWER, 32'h0000_3FFF);
    highpass_filter <= 1'b1;
    wb(1'b0, `RPE_ADR_STATUS, 32'h0000_0000);
    chk("hpf status", 32'h2, q & 32'h2);
    // dc estimate starts at zero: the first filtered pair is raw, the next loses 4
    repeat (2) push(16'h4000, 16'h4000);
    repeat (300) @(posedge clk);
    rd("power hpf", `RPE_ADR_POWER, 32'h0000_7FFB);
    highpass_filter <= 1'b0;
    // same load from a fresh reset under each rate select
    for (int s = 0; s < 2; s++) begin
      reset_dut();
      sel <= s[0];
      wb(1'b1, `RPE_ADR_LR_THRESH, 32'h0000_0080);
      repeat (8) push(16'h4000, 16'h4000);
      repeat (700) @(posedge clk);
      cnt[s] = cal_seen;
    end
    chk("rate select", 32'h1, {31'h0, cnt[1] > cnt[0]});
    reset_dut();
    wb(1'b1, `RPE_ADR_LR_THRESH, 32'h0000_0000);
    wb(1'b1, `RPE_ADR_CTRL, 32'h0000_0000);
    repeat (4) push(16'hC000, 16'h4000);
    #1;
    chk("fifo full", 32'h0, {31'h0, ready});
    wb(1'b1, `RPE_ADR_CTRL, 32'h0000_0001);
    repeat (700) @(posedge clk);
    chk("flag negative", 32'h1, {31'h0, flag});
    repeat (12) push(16'h4000, 16'h4000);
    repeat (700) @(posedge clk);
    chk("flag positive", 32'h0, {31'h0, flag});
    chk("steps", 32'd16, {16'h0, steps});
    chk("cal pulses", 32'd16, {16'h0, cal_seen});
    chk("step order", 32'h0, {31'h0, order_bad});
    rd("lr count", `RPE_ADR_LR_COUNT, 32'd16);
    close_out();
  end
endmodule
